// *** cap_ctrl_model.sv ***
// Controller model: differential clock, command pins, parity one crossing late.
`timescale 1ns/1ps
module cap_ctrl_model
  import cap_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            run,
  input  wire cap_cmd_t        nextCmd,
  input  wire logic [CS_W-1:0] nextCs,
  input  wire logic            nextFlip,
  output logic                 ckT,
  output logic                 ckC,
  output cap_cmd_t             cmd,
  output logic [CS_W-1:0]      chipSelN,
  output logic                 parity
);
  logic [3:0] phase   = 4'h0;
  logic       lastPar = 1'h0;
  initial {ckT, ckC} = 2'h0;
  // The clock rises at phase 6, falls at phase 0 and stops low-low only there.
  always @(negedge clk_sys) begin
    phase <= (phase == 4'hb || (phase == 4'h0 && !run)) ? 4'h0 : phase + 4'h1;
    if (phase == 4'h6) begin
      ckT <= 1'h1;
      ckC <= 1'h0;
    end
    if (phase == 4'h0) begin
      ckT      <= 1'h0;
      ckC      <= run;
      cmd      <= nextCmd;
      chipSelN <= nextCs;
      parity   <= lastPar;
      lastPar  <= ^nextCmd ^ nextFlip;
    end
  end
endmodule : cap_ctrl_model

// *** cap_parity_checker.sv ***
// Parity checker with open-drain error and registered command outputs.
`timescale 1ns/1ps
module cap_parity_checker
  import cap_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  input  wire logic            ckT,
  input  wire logic            ckC,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic [BANK_W-1:0] bankAddrIn,
  input  wire logic            rowStrobeInN,
  input  wire logic            colStrobeInN,
  input  wire logic            writeEnInN,
  input  wire logic            parityIn,
  input  wire logic [CS_W-1:0] chipSelectInN,
  input  wire logic            quadSelectEnableN,
  input  wire logic            floatEnableBit,
  input  wire logic            threeCycleTiming,
  output logic                 parityErrorN,
  output logic                 parityErrorOe,
  output cap_cmd_t             cmdOut,
  output logic                 cmdOutOe
);

  // ----------------------------------------------------------------
  // Pin synchronisation and crossing detection
  // ----------------------------------------------------------------
  cap_pins_t pinsRaw;
  cap_pins_t pinsS;
  logic      prevT_ff;
  logic      prevC_ff;
  logic      crossing;
  logic      standby;
  logic      anySel;

  assign pinsRaw = '{ckT: ckT, ckC: ckC,
                     cmd: '{addr: addrIn, bankAddr: bankAddrIn, rowStrobeN: rowStrobeInN,
                            colStrobeN: colStrobeInN, writeEnN: writeEnInN},
                     parity: parityIn, chipSelN: chipSelectInN, quadSelEnN: quadSelectEnableN,
                     floatEnable: floatEnableBit, threeCycle: threeCycleTiming};

  cap_sync #(.W(PINS_W)) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .din     (pinsRaw),
    .dout    (pinsS)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prevT_ff <= 1'h0;
      prevC_ff <= 1'h1;
    end else begin
      prevT_ff <= pinsS.ckT;
      prevC_ff <= pinsS.ckC;
    end
  end

  // A crossing is true clock going high while the complement goes low.
  assign crossing = pinsS.ckT && !pinsS.ckC && !prevT_ff && prevC_ff;
  assign standby  = !pinsS.ckT && !pinsS.ckC;
  // Chip selects 3:2 only count in quad mode.
  assign anySel   = pinsS.quadSelEnN ? !(&pinsS.chipSelN[1:0]) : !(&pinsS.chipSelN);

  // ----------------------------------------------------------------
  // Parity pipeline
  // ----------------------------------------------------------------
  logic sumA_ff;
  logic selA_ff;
  logic failB_ff;
  logic failC_ff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sumA_ff  <= 1'h0;
      selA_ff  <= 1'h0;
      failB_ff <= 1'h0;
      failC_ff <= 1'h0;
    end else if (crossing) begin
      sumA_ff  <= cap_cmd_parity(pinsS.cmd);
      selA_ff  <= anySel;
      failB_ff <= selA_ff && (sumA_ff ^ pinsS.parity);
      failC_ff <= failB_ff;
    end
  end

  // ----------------------------------------------------------------
  // Error output and latch
  // ----------------------------------------------------------------
  logic [1:0] holdCnt_ff;
  logic       parityErrorN_ff;
  logic       parityErrorOe_ff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n || standby) begin
      parityErrorN_ff  <= ERR_N_RST;
      parityErrorOe_ff <= OE_RST;
      holdCnt_ff       <= HOLD_RST;
    end else if (crossing) begin
      if (!parityErrorN_ff) begin
        if (holdCnt_ff == HOLD_LAST) begin
          parityErrorN_ff  <= 1'h1;
          parityErrorOe_ff <= 1'h0;
          holdCnt_ff       <= HOLD_RST;
        end else begin
          holdCnt_ff <= holdCnt_ff + 2'h1;
        end
      end else begin
        parityErrorN_ff  <= !failC_ff;
        parityErrorOe_ff <= failC_ff;
        holdCnt_ff       <= HOLD_RST;
      end
    end
  end

  assign parityErrorN  = parityErrorN_ff;
  assign parityErrorOe = parityErrorOe_ff;

  // ----------------------------------------------------------------
  // Command outputs
  // ----------------------------------------------------------------
  cap_cmd_t cmdOut_ff;
  logic     cmdOutOe_ff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n || standby) begin
      cmdOut_ff   <= '0;
      cmdOutOe_ff <= 1'h0;
    end else if (crossing) begin
      if (anySel) begin
        cmdOut_ff   <= pinsS.cmd;
        cmdOutOe_ff <= 1'h1;
      end else if (pinsS.floatEnable && !pinsS.threeCycle) begin
        cmdOutOe_ff <= 1'h0;
      end
    end
  end

  assign cmdOut   = cmdOut_ff;
  assign cmdOutOe = cmdOutOe_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // The clock supervision relies on the system keeping the clock alive.
  default clocking cb @(posedge clk_sys); endclocking

  sum_cover_a: assert property (disable iff (!reset_n)
    crossing |=> sumA_ff == ^{$past(pinsS.cmd.addr), $past(pinsS.cmd.bankAddr), $past(pinsS.cmd.rowStrobeN),
                             $past(pinsS.cmd.colStrobeN), $past(pinsS.cmd.writeEnN)})
    else $error("parity sum wrong");
  parity_eval_a: assert property (disable iff (!reset_n)
    crossing && selA_ff && (sumA_ff ^ pinsS.parity) |=> failB_ff)
    else $error("odd parity not flagged");
  err_latency_a: assert property (disable iff (!reset_n)
    crossing && failC_ff && parityErrorN && !standby |=> !parityErrorN && parityErrorOe)
    else $error("error not asserted on time");
  hold_release_a: assert property (disable iff (!reset_n)
    crossing && !parityErrorN && holdCnt_ff == HOLD_LAST && !standby |=> parityErrorN)
    else $error("error held too long");
  latch_keep_a: assert property (disable iff (!reset_n)
    crossing && !parityErrorN && holdCnt_ff != HOLD_LAST && !standby |=> !parityErrorN)
    else $error("latched error released early");
  deselect_ok_a: assert property (disable iff (!reset_n)
    crossing && !anySel |=> !selA_ff ##0 (!crossing [*1]))
    else $error("deselect treated as command");
  float_ctrl_a: assert property (disable iff (!reset_n)
    crossing && !anySel && pinsS.threeCycle && !standby |=> $stable(cmdOutOe))
    else $error("float under three-cycle timing");
  reset_high_a: assert property (
    !reset_n || (reset_n && standby) |=> parityErrorN && !parityErrorOe)
    else $error("error low in reset or standby");
  no_cross_a: assert property (disable iff (!reset_n)
    !crossing && !standby |=> $stable(parityErrorN))
    else $error("error changed without crossing");

  // ----------------------------------------------------------------
  // Pipeline, latch and command output checks
  // ----------------------------------------------------------------
  sel_track_a: assert property (disable iff (!reset_n)
    crossing |=> selA_ff == $past(anySel))
    else $error("select not staged");
  fail_stage_a: assert property (disable iff (!reset_n)
    crossing |=> failC_ff == $past(failB_ff))
    else $error("failure stage skipped");
  desel_clear_a: assert property (disable iff (!reset_n)
    crossing && !selA_ff |=> !failB_ff)
    else $error("deselected command flagged");
  err_only_fail_a: assert property (disable iff (!reset_n)
    crossing && parityErrorN && !failC_ff |=> parityErrorN)
    else $error("error without failure");
  oe_pair_a: assert property (disable iff (!reset_n)
    parityErrorOe != parityErrorN)
    else $error("error enable and level disagree");
  hold_range_a: assert property (disable iff (!reset_n)
    holdCnt_ff <= HOLD_LAST)
    else $error("hold counter out of range");
  hold_count_a: assert property (disable iff (!reset_n)
    crossing && !parityErrorN && holdCnt_ff != HOLD_LAST |=> holdCnt_ff == $past(holdCnt_ff) + 2'h1)
    else $error("hold counter did not advance");
  hold_rearm_a: assert property (disable iff (!reset_n)
    crossing && parityErrorN |=> holdCnt_ff == HOLD_RST)
    else $error("hold counter not cleared");
  hold_idle_a: assert property (disable iff (!reset_n)
    !crossing && !standby |=> $stable(holdCnt_ff))
    else $error("hold counter moved without crossing");
  cmd_capture_a: assert property (disable iff (!reset_n)
    crossing && anySel |=> cmdOutOe && cmdOut == $past(pinsS.cmd))
    else $error("selected command not driven");
  cmd_keep_a: assert property (disable iff (!reset_n)
    crossing && !anySel |=> $stable(cmdOut))
    else $error("command changed on deselect");
  float_on_a: assert property (disable iff (!reset_n)
    crossing && !anySel && pinsS.floatEnable && !pinsS.threeCycle |=> !cmdOutOe)
    else $error("outputs not floated on deselect");
  standby_float_a: assert property (disable iff (!reset_n)
    standby |=> !cmdOutOe)
    else $error("outputs driven in standby");
  cmd_idle_a: assert property (disable iff (!reset_n)
    !crossing && !standby |=> $stable(cmdOutOe))
    else $error("command enable moved without crossing");

  err_seen_c:   cover property (disable iff (!reset_n) $fell(parityErrorN));
  err_clear_c:  cover property (disable iff (!reset_n) $rose(parityErrorN));
  float_seen_c: cover property (disable iff (!reset_n) $fell(cmdOutOe));
  hold_full_c:  cover property (disable iff (!reset_n) crossing && !parityErrorN && holdCnt_ff == HOLD_LAST);
  quad_sel_c:   cover property (disable iff (!reset_n) crossing && !pinsS.quadSelEnN && anySel);

endmodule : cap_parity_checker

// *** cap_pkg.sv ***
// Package of constants and types for the command/address parity checker.
// Notes on behaviour
// - Parity covers sixteen address, three bank, row, column and write strobes only.
// - Selected command: odd count of highs plus parity bit drives error low.
// - Error goes low three clocks after the failing command's crossing.
// - Error stays low exactly two clocks, or until reset goes low or the clock stops low-low in standby.
// - Results change the error only while it is high at the crossing.
// - Full deselect gives error high with the same three-clock latency.
// - Deselect floats or holds outputs by float bit; three-cycle timing forbids floating.
package cap_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned BANK_W      = 3;
  localparam int unsigned CS_W        = 4;
  localparam int unsigned ERR_LATENCY = 3;
  localparam int unsigned HOLD_CYCLES = 2;
  localparam logic [1:0]  HOLD_LAST   = 2'h1;
  localparam logic [1:0]  HOLD_RST    = 2'h0;
  localparam logic        ERR_N_RST   = 1'h1;
  localparam logic        OE_RST      = 1'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BANK_W-1:0] bankAddr;
    logic              rowStrobeN;
    logic              colStrobeN;
    logic              writeEnN;
  } cap_cmd_t;

  typedef struct packed {
    logic            ckT;
    logic            ckC;
    cap_cmd_t        cmd;
    logic            parity;
    logic [CS_W-1:0] chipSelN;
    logic            quadSelEnN;
    logic            floatEnable;
    logic            threeCycle;
  } cap_pins_t;

  localparam int unsigned PINS_W = $bits(cap_pins_t);

  function automatic logic cap_cmd_parity(input cap_cmd_t c);
    cap_cmd_parity = ^c;
  endfunction : cap_cmd_parity

endpackage : cap_pkg

// *** cap_sync.sv ***
// Two-flop synchroniser for the sampled pin bundle.
`timescale 1ns/1ps
module cap_sync
  import cap_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule : cap_sync

// *** test_cmd_addr_parity_checker.sv ***
// Self-checking testbench for the command/address parity checker.
`timescale 1ns/1ps
module test_cmd_addr_parity_checker
  import cap_pkg::*;
;
  logic            clk_sys  = 1'h0;
  logic            reset_n  = 1'h0;
  logic            quadSelN = 1'h1;
  logic            floatEn  = 1'h0;
  logic            threeCyc = 1'h0;
  logic            run      = 1'h1;
  logic            nextFlip = 1'h0;
  logic [CS_W-1:0] nextCs   = '1;
  cap_cmd_t        nextCmd  = '0;
  cap_cmd_t        cmdPins;
  cap_cmd_t        cmdOut;
  logic [CS_W-1:0] chipSelN;
  logic            ckT, ckC, parityIn, errN, errOe, cmdOutOe;
  int              failures   = 0;
  int              num_checks = 0;

  always #25 clk_sys = ~clk_sys;

  cap_ctrl_model ctrl (.clk_sys(clk_sys), .run(run), .nextCmd(nextCmd), .nextCs(nextCs), .nextFlip(nextFlip),
    .ckT(ckT), .ckC(ckC), .cmd(cmdPins), .chipSelN(chipSelN), .parity(parityIn));

  cap_parity_checker dut (.clk_sys(clk_sys), .reset_n(reset_n), .ckT(ckT), .ckC(ckC), .addrIn(cmdPins.addr),
    .bankAddrIn(cmdPins.bankAddr), .rowStrobeInN(cmdPins.rowStrobeN), .colStrobeInN(cmdPins.colStrobeN),
    .writeEnInN(cmdPins.writeEnN), .parityIn(parityIn), .chipSelectInN(chipSelN), .quadSelectEnableN(quadSelN),
    .floatEnableBit(floatEn), .threeCycleTiming(threeCyc), .parityErrorN(errN), .parityErrorOe(errOe),
    .cmdOut(cmdOut), .cmdOutOe(cmdOutOe));

  task automatic finish_test;
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ck(input logic lvl);
    for (int n = 0; n < 40 && ckT !== lvl; n++)
      @(posedge clk_sys);
    if (ckT !== lvl) begin
      failures++;
      finish_test();
    end
  endtask : wait_ck

  // One crossing; returns at a falling edge, the error output showing the crossing before it.
  task automatic step(input cap_cmd_t c, input logic [CS_W-1:0] cs, input logic flip);
    @(posedge clk_sys);
    nextCmd  = c;
    nextCs   = cs;
    nextFlip = flip;
    wait_ck(1'h1);
    wait_ck(1'h0);
    @(negedge clk_sys);
  endtask : step

  task automatic seq(input logic [CS_W-1:0] cs, input logic [7:0] flips, input logic [7:0] exp);
    for (int i = 0; i < 8; i++) begin
      step(cap_cmd_t'(22'h0abcde ^ (22'h1 << (3 * i))), cs, flips[i]);
      check(errN, exp[i]);
      check(errOe, !exp[i]);
    end
  endtask : seq

  task automatic s_parity;
    seq(4'he, 8'h00, 8'hff);
    seq(4'he, 8'h01, 8'hcf);
    seq(4'hd, 8'h03, 8'hcf);
  endtask : s_parity

  task automatic s_select;
    seq(4'hf, 8'hff, 8'hff);
    @(negedge clk_sys);
    quadSelN = 1'h0;
    seq(4'h7, 8'h01, 8'hcf);
    @(negedge clk_sys);
    quadSelN = 1'h1;
    seq(4'h7, 8'h01, 8'hff);
  endtask : s_select

  task automatic s_cmd_out;
    @(negedge clk_sys);
    floatEn = 1'h1;
    step(22'h0123ab, 4'he, 1'h0);
    step(22'h3fffff, 4'hf, 1'h0);
    check(cmdOut, 22'h0123ab);
    check(cmdOutOe, 1'h1);
    step(22'h000000, 4'hf, 1'h0);
    check(cmdOutOe, 1'h0);
    @(negedge clk_sys);
    threeCyc = 1'h1;
    step(22'h2aaaaa, 4'he, 1'h0);
    step(22'h155555, 4'hf, 1'h0);
    step(22'h000000, 4'hf, 1'h0);
    check(cmdOutOe, 1'h1);
    check(cmdOut, 22'h2aaaaa);
    @(negedge clk_sys);
    floatEn  = 1'h0;
    threeCyc = 1'h0;
  endtask : s_cmd_out

  task automatic s_reset_standby;
    step(22'h155555, 4'he, 1'h1);
    repeat (4) step(22'h155555, 4'he, 1'h0);
    check(errN, 1'h0);
    reset_n = 1'h0;
    repeat (4) @(negedge clk_sys);
    check(errN, 1'h1);
    check(errOe, 1'h0);
    reset_n = 1'h1;
    seq(4'he, 8'h00, 8'hff);
    @(posedge clk_sys);
    run = 1'h0;
    repeat (30) @(negedge clk_sys);
    check(errN, 1'h1);
    check(cmdOutOe, 1'h0);
    @(posedge clk_sys);
    run = 1'h1;
    seq(4'he, 8'h01, 8'hcf);
  endtask : s_reset_standby

  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'h1;
    s_parity();
    s_select();
    s_cmd_out();
    s_reset_standby();
    finish_test();
  end
endmodule : test_cmd_addr_parity_checker
